// >>> src/elastic_word_store.sv
// How it works
// - Terminal and trunk modes recover a 1536 kHz clock; divide by eight for bits.
// - Phase at the frame edge is measured; one tracking step every 250 us.
// - Each step lengthens or shortens one 1536 kHz cycle by 65 ns.
// - Every other line clock is derived from the corrected recovered clock.
// - Trunk mode stores three B1 octets, three B2 octets and six D bits.
// - The store absorbs 50 us wander; beyond that a slip is flagged.
// - With the warning bit set, wander over 25 us raises a slip warning.
// - Terminal mode exports 1536 kHz, 768 kHz and 8 kHz clocks locked to line.
// - High to low ratios are 3:2 data clock, 1:2 frame sync, 1:1 768 kHz.
// - Second aux clock runs 32 kHz with select 0, 16 kHz even with select 1.
// - A tracking step may stretch or shrink one high or low phase, whichever it lands in, every 250 us.
// - The 1536 and 768 kHz outputs are registered and always change on the master clock's rising edge.
// - Trunk mode puts the recovered 1536 kHz clock on the first aux pin.
// - Level detector reports line signal, also under analog loop in terminal/trunk.
// - Network and line termination loops report only the own looped signal.
package line_clock_pkg;
    localparam longint REF_CLK_HZ      = 40000000;
    localparam longint REC_CLK_HZ      = 1536000;
    localparam int     PHASE_W         = 32;
    localparam longint PHASE_INC       = (REC_CLK_HZ << PHASE_W) / REF_CLK_HZ;
    localparam longint STEP_NS         = 65;
    localparam longint PHASE_STEP      = (STEP_NS * REC_CLK_HZ << PHASE_W) / 1000000000;
    localparam longint HIGH_LIMIT      = ((64'h1 << PHASE_W) * 3) / 5;
    localparam longint TRACK_US        = 250;
    localparam int     TRACK_CYC       = int'((TRACK_US * REF_CLK_HZ) / 1000000);
    localparam longint WARN_US         = 25;
    localparam int     WARN_CYC        = int'((WARN_US * REF_CLK_HZ) / 1000000);
    localparam longint SLIP_US         = 50;
    localparam int     SLIP_CYC        = int'((SLIP_US * REF_CLK_HZ) / 1000000);
    localparam int     TICKS_PER_FRAME = 192;
    localparam int     BIT_DIV_BIT     = 2;
    localparam int     SYNC_HIGH_TICKS = 64;
    localparam int     X32_TICKS       = 48;
    localparam int     X16_TICKS       = 96;
    localparam int     B_OCTET_W       = 8;
    localparam int     D_BITS_W        = 2;
    localparam int     STORE_DEPTH     = 3;
    localparam int     STORE_W         = 2 * B_OCTET_W + D_BITS_W;
    localparam int     TIMER_W         = 16;

    typedef enum logic [1:0] {
        MODE_TERMINAL,
        MODE_NETWORK_TERM,
        MODE_TRUNK,
        MODE_LINE_TERM
    } line_mode_e;
endpackage : line_clock_pkg

`timescale 1ns/1ps
module elastic_word_store #(
    parameter int WIDTH    = line_clock_pkg::STORE_W,
    parameter int DEPTH    = line_clock_pkg::STORE_DEPTH,
    parameter int WARN_LIM = line_clock_pkg::WARN_CYC,
    parameter int SLIP_LIM = line_clock_pkg::SLIP_CYC
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             enable,
    input  wire logic             warnEnable,
    input  wire logic             wrValid,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic             rdReq,
    output logic      [WIDTH-1:0] rdData,
    output logic                  rdValid,
    output logic      [1:0]       fillLevel,
    output logic                  slipWarn,
    output logic                  slipLost
);
    localparam int TW = line_clock_pkg::TIMER_W;

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [1:0]       wrPtr_r;
    logic [1:0]       rdPtr_r;
    logic [TW-1:0]    sinceWr_r;
    logic [TW-1:0]    centre_r;
    logic             centreOk_r;
    logic [TW-1:0]    dev;
    logic             doWr;
    logic             doRd;
    logic             overrun;
    logic             underrun;
    logic             wanderOut;

    function automatic logic [1:0] wrapInc(input logic [1:0] p);
        wrapInc = (p == 2'(DEPTH - 1)) ? 2'h0 : p + 2'h1;
    endfunction : wrapInc

    assign overrun   = enable && wrValid && (fillLevel == 2'(DEPTH));
    assign underrun  = enable && rdReq && (fillLevel == 2'h0);
    assign doWr      = enable && wrValid && !overrun;
    assign doRd      = enable && rdReq && !underrun;
    assign dev       = (sinceWr_r > centre_r) ? sinceWr_r - centre_r : centre_r - sinceWr_r;
    assign wanderOut = enable && rdReq && centreOk_r && (dev > TW'(SLIP_LIM));

    always_ff @(posedge ref_clk) begin
        if (doWr) begin
            mem_r[wrPtr_r] <= wrData;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wrPtr_r   <= 2'h0;
            rdPtr_r   <= 2'h0;
            fillLevel <= 2'h0;
        end else if (!enable) begin
            wrPtr_r   <= 2'h0;
            rdPtr_r   <= 2'h0;
            fillLevel <= 2'h0;
        end else begin
            if (doWr) begin
                wrPtr_r <= wrapInc(wrPtr_r);
            end
            if (doRd) begin
                rdPtr_r <= wrapInc(rdPtr_r);
            end
            fillLevel <= fillLevel + 2'(doWr) - 2'(doRd);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdData  <= '0;
            rdValid <= 1'b0;
        end else begin
            rdValid <= doRd;
            if (doRd) begin
                rdData <= mem_r[rdPtr_r];
            end
        end
    end

    // The write-to-read distance seen at the first read is taken as centre, so
    // wander is measured against where the store settled, not a fixed point.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sinceWr_r  <= '0;
            centre_r   <= '0;
            centreOk_r <= 1'b0;
        end else begin
            if (wrValid) begin
                sinceWr_r <= '0;
            end else if (sinceWr_r != '1) begin
                sinceWr_r <= sinceWr_r + 1'b1;
            end
            if (!enable) begin
                centreOk_r <= 1'b0;
            end else if (rdReq && (!centreOk_r || wanderOut)) begin
                centre_r   <= sinceWr_r;
                centreOk_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            slipWarn <= 1'b0;
            slipLost <= 1'b0;
        end else begin
            slipLost <= wanderOut || overrun || underrun;
            slipWarn <= warnEnable && enable && rdReq && centreOk_r && (dev > TW'(WARN_LIM));
        end
    end
endmodule : elastic_word_store

// >>> src/line_clock_recovery_elastic_buffer.sv
`timescale 1ns/1ps
module line_clock_recovery_elastic_buffer #(
    parameter int TRACK_CYCLES = line_clock_pkg::TRACK_CYC,
    parameter int WORD_W       = line_clock_pkg::STORE_W
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic [1:0]        lineMode,
    input  wire logic              slipWarnSelect,
    input  wire logic              lineFrameEdge,
    input  wire logic              lineLevelAbove,
    input  wire logic              ownLoopLevel,
    input  wire logic              analogLoopClosed,
    input  wire logic              lineWordValid,
    input  wire logic [WORD_W-1:0] lineWord,
    input  wire logic              portWordReq,
    output logic      [WORD_W-1:0] portWord,
    output logic                   portWordValid,
    output logic      [1:0]        storeFill,
    output logic                   recoveredClock,
    output logic                   recoveredBitClock,
    output logic                   portDataClock,
    output logic                   frameSyncClock,
    output logic                   auxClockOutA,
    output logic                   auxClockOutB,
    output logic                   signalPresent,
    output logic                   slipWarning,
    output logic                   slipDetected
);
    localparam int PW = line_clock_pkg::PHASE_W;
    localparam logic [PW-1:0] INC     = PW'(line_clock_pkg::PHASE_INC);
    localparam logic [PW-1:0] STEP    = PW'(line_clock_pkg::PHASE_STEP);
    localparam logic [PW-1:0] HIGH_LT = PW'(line_clock_pkg::HIGH_LIMIT);
    localparam logic [PW-1:0] DEAD    = PW'(line_clock_pkg::PHASE_STEP / 2);

    line_clock_pkg::line_mode_e mode;
    logic              terminal;
    logic              trunk;
    logic              recovering;

    logic [2:0]        edgeSync_r;
    logic [1:0]        levelSync_r;
    logic [1:0]        loopSync_r;
    logic              frameEdge;

    logic [PW-1:0]     phase_r;
    logic [PW:0]       phaseSum;
    logic [PW-1:0]     phaseAdd;
    logic              tick;
    logic [13:0]       trackCnt_r;
    logic              trackDue;
    logic [1:0]        errSign_r;
    logic [7:0]        tickCnt_r;

    assign mode       = line_clock_pkg::line_mode_e'(lineMode);
    assign terminal   = (mode == line_clock_pkg::MODE_TERMINAL);
    assign trunk      = (mode == line_clock_pkg::MODE_TRUNK);
    assign recovering = terminal || trunk;

    // Pin inputs pass two flops; the third stage only feeds the edge detector.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            edgeSync_r  <= 3'h0;
            levelSync_r <= 2'h0;
            loopSync_r  <= 2'h0;
        end else begin
            edgeSync_r  <= {edgeSync_r[1:0], lineFrameEdge};
            levelSync_r <= {levelSync_r[0], lineLevelAbove};
            loopSync_r  <= {loopSync_r[0], ownLoopLevel};
        end
    end

    assign frameEdge = edgeSync_r[1] && !edgeSync_r[2];

    // The 1536 kHz clock comes from a phase accumulator; a wrap is one cycle.
    // A tracking step moves the phase once, so only the cycle it lands in is
    // stretched or shortened and later cycles keep the nominal period.
    always_comb begin
        phaseAdd = INC;
        if (trackDue && errSign_r == 2'b01) begin
            phaseAdd = INC + STEP;
        end else if (trackDue && errSign_r == 2'b10) begin
            phaseAdd = INC - STEP;
        end
    end

    assign phaseSum = {1'b0, phase_r} + {1'b0, phaseAdd};
    assign tick     = phaseSum[PW];
    assign trackDue = (trackCnt_r == 14'(TRACK_CYCLES - 1));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase_r <= '0;
        end else if (!recovering) begin
            phase_r <= '0;
        end else begin
            phase_r <= phaseSum[PW-1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            trackCnt_r <= 14'h0;
        end else if (!recovering || trackDue) begin
            trackCnt_r <= 14'h0;
        end else begin
            trackCnt_r <= trackCnt_r + 14'h1;
        end
    end

    // Sign of the last phase error: 01 clock lags, 10 clock leads, 00 none.
    // A marker that lands on the interval end is kept for the next interval;
    // with a frame period that is a multiple of the interval it would otherwise
    // be lost every time and tracking would never act.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            errSign_r <= 2'b00;
        end else if (!recovering) begin
            errSign_r <= 2'b00;
        end else if (frameEdge) begin
            if (phase_r < DEAD || phase_r > ~DEAD) begin
                errSign_r <= 2'b00;
            end else if (phase_r[PW-1]) begin
                errSign_r <= 2'b01;
            end else begin
                errSign_r <= 2'b10;
            end
        end else if (trackDue) begin
            errSign_r <= 2'b00;
        end
    end

    // The divided clocks count the recovered tick, never the master clock; the 1536 kHz outputs compare the accumulator phase.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tickCnt_r <= 8'h0;
        end else if (!recovering) begin
            tickCnt_r <= 8'h0;
        end else if (tick) begin
            if (tickCnt_r == 8'(line_clock_pkg::TICKS_PER_FRAME - 1)) begin
                tickCnt_r <= 8'h0;
            end else begin
                tickCnt_r <= tickCnt_r + 8'h1;
            end
        end
    end

    function automatic logic lowerPart(input logic [7:0] cnt, input int period);
        lowerPart = ((cnt % 8'(period)) < 8'(period / 2));
    endfunction : lowerPart

    // Edges follow the accumulator, so a step can move any of them by whole
    // master periods; all outputs are registered and sit on a rising master edge.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            recoveredClock    <= 1'b0;
            recoveredBitClock <= 1'b0;
            portDataClock     <= 1'b0;
            frameSyncClock    <= 1'b0;
            auxClockOutA      <= 1'b0;
            auxClockOutB      <= 1'b0;
        end else begin
            recoveredClock    <= recovering && (phase_r < HIGH_LT);
            recoveredBitClock <= recovering && !tickCnt_r[line_clock_pkg::BIT_DIV_BIT];
            portDataClock     <= terminal && (phase_r < HIGH_LT);
            frameSyncClock    <= terminal && (tickCnt_r < 8'(line_clock_pkg::SYNC_HIGH_TICKS));
            if (terminal) begin
                auxClockOutA <= !tickCnt_r[0];
            end else begin
                auxClockOutA <= trunk && (phase_r < HIGH_LT);
            end
            if (!terminal) begin
                auxClockOutB <= 1'b0;
            end else if (slipWarnSelect) begin
                auxClockOutB <= lowerPart(tickCnt_r, line_clock_pkg::X16_TICKS);
            end else begin
                auxClockOutB <= lowerPart(tickCnt_r, line_clock_pkg::X32_TICKS);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            signalPresent <= 1'b0;
        end else if (analogLoopClosed && !recovering) begin
            signalPresent <= loopSync_r[1];
        end else begin
            signalPresent <= levelSync_r[1];
        end
    end

    elastic_word_store #(
        .WIDTH    (WORD_W),
        .DEPTH    (line_clock_pkg::STORE_DEPTH),
        .WARN_LIM (line_clock_pkg::WARN_CYC),
        .SLIP_LIM (line_clock_pkg::SLIP_CYC)
    ) store (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .enable     (trunk),
        .warnEnable (slipWarnSelect),
        .wrValid    (lineWordValid),
        .wrData     (lineWord),
        .rdReq      (portWordReq),
        .rdData     (portWord),
        .rdValid    (portWordValid),
        .fillLevel  (storeFill),
        .slipWarn   (slipWarning),
        .slipLost   (slipDetected)
    );
endmodule : line_clock_recovery_elastic_buffer

// >>> test/clock_port_monitor.sv
`timescale 1ns/1ps
module clock_port_monitor (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic [1:0] lineMode,
    input wire logic       slipWarnSelect,
    input wire logic       lineWordValid,
    input wire logic       portWordReq,
    input wire logic       portWordValid,
    input wire logic [1:0] storeFill,
    input wire logic       portDataClock,
    input wire logic       frameSyncClock,
    input wire logic       slipWarning,
    input wire logic       slipDetected
);
    localparam logic [1:0] TRK = line_clock_pkg::MODE_TRUNK;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence s_read;
        lineMode == TRK && portWordReq && storeFill != 2'h0;
    endsequence
    sequence s_dry_read;
        lineMode == TRK && portWordReq && storeFill == 2'h0 && !lineWordValid;
    endsequence
    AST_READ_ANSWER: assert property (s_read |=> portWordValid)
        else $error("stored word not returned");
    AST_READ_CAUSE: assert property (portWordValid |-> $past(portWordReq) && $past(lineMode) == TRK)
        else $error("word without a read");
    AST_DRY_SLIP: assert property (s_dry_read |=> slipDetected && !portWordValid)
        else $error("empty read not flagged");
    AST_FULL_SLIP: assert property (lineMode == TRK && lineWordValid && !portWordReq && storeFill == 2'h3
        |=> slipDetected) else $error("full write not flagged");
    AST_FILL_UP: assert property (lineMode == TRK && lineWordValid && !portWordReq && storeFill != 2'h3
        |=> storeFill == $past(storeFill) + 2'h1) else $error("write not stored");
    AST_FILL_DOWN: assert property (s_read ##0 !lineWordValid |=> storeFill == $past(storeFill) - 2'h1)
        else $error("read not removed");
    AST_WARN_GATE: assert property (slipWarning |-> $past(slipWarnSelect) && $past(lineMode) == TRK)
        else $error("warning while disabled");
    AST_TERM_ONLY: assert property ((lineMode != line_clock_pkg::MODE_TERMINAL) [*2]
        |-> !portDataClock && !frameSyncClock) else $error("port clocks outside terminal mode");
endmodule : clock_port_monitor

// >>> test/line_term_model.sv
`timescale 1ns/1ps
module line_term_model #(
    parameter int FRAME_CYC = 5000,
    parameter int START_CYC = 0
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    output logic      lineFrameEdge
);
    int count_r;
    // The marker lasts three cycles so that the two-stage synchroniser cannot miss it.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_r <= START_CYC;
        end else begin
            count_r <= (count_r == FRAME_CYC - 1) ? 0 : count_r + 1;
        end
    end
    assign lineFrameEdge = count_r >= FRAME_CYC - 3;
endmodule : line_term_model

// >>> test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int         N   = 20000;
    localparam int         W   = line_clock_pkg::STORE_W;
    localparam longint     R   = line_clock_pkg::REC_CLK_HZ;
    localparam longint     RF  = line_clock_pkg::REF_CLK_HZ;
    localparam logic [1:0] TRM = line_clock_pkg::MODE_TERMINAL;
    localparam logic [1:0] TRK = line_clock_pkg::MODE_TRUNK;
    logic         ref_clk = 1'b0;
    logic         rst = 1'b1;
    logic [1:0]   lineMode = 2'h0;
    logic         slipWarnSelect = 1'b0;
    logic         lineLevelAbove = 1'b0;
    logic         ownLoopLevel = 1'b0;
    logic         analogLoopClosed = 1'b0;
    logic         lineWordValid = 1'b0;
    logic         portWordReq = 1'b0;
    logic [W-1:0] lineWord = '0;
    logic [W-1:0] portWord;
    logic [W-1:0] q[$];
    logic [1:0]   storeFill;
    wire  [5:0]   clks;
    logic [15:0]  seed = 16'h17F7;
    logic         lineFrameEdge, portWordValid, signalPresent, slipWarning, slipDetected;
    int           rises[6], highs[6];
    int           n_fail = 0, checked = 0, cyc = 0, lastWr = 0, centre = -1;
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    // The start offset puts the first marker far from a tick, so the tracker has to pull in.
    line_term_model #(.FRAME_CYC(int'(RF / 8000)), .START_CYC(13)) far_u (
        .ref_clk(ref_clk), .rst(rst), .lineFrameEdge(lineFrameEdge));
    line_clock_recovery_elastic_buffer #(.TRACK_CYCLES(200)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .lineMode(lineMode), .slipWarnSelect(slipWarnSelect),
        .lineFrameEdge(lineFrameEdge), .lineLevelAbove(lineLevelAbove), .ownLoopLevel(ownLoopLevel),
        .analogLoopClosed(analogLoopClosed), .lineWordValid(lineWordValid), .lineWord(lineWord),
        .portWordReq(portWordReq), .portWord(portWord), .portWordValid(portWordValid), .storeFill(storeFill),
        .recoveredClock(clks[0]), .recoveredBitClock(clks[1]), .portDataClock(clks[2]),
        .frameSyncClock(clks[3]), .auxClockOutA(clks[4]), .auxClockOutB(clks[5]),
        .signalPresent(signalPresent), .slipWarning(slipWarning), .slipDetected(slipDetected));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic near(input int got, input int exp, input int tol);
        return got - exp <= tol && exp - got <= tol;
    endfunction : near
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    task automatic reset_dut(input int n);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (n) @(posedge ref_clk);
        rst <= 1'b0;
        q.delete();
        centre = -1;
    endtask : reset_dut
    task automatic clocks(input logic [1:0] m, input logic sel);
        logic [5:0] prev;
        longint     hz[6];
        int         hi[6];
        int         since;
        logic       pe;
        hz = '{R, R / 8, R, 8000, R / 2, sel ? 16000 : 32000};
        if (m == TRK) hz = '{R, R / 8, 0, 0, R, 0};
        hi = '{0, 0, 600, 333, 500, 500};
        rises = '{default: 0};
        highs = '{default: 0};
        @(posedge ref_clk);
        lineMode <= m;
        slipWarnSelect <= sel;
        repeat (400) @(posedge ref_clk);
        #1 prev = clks;
        pe = lineFrameEdge;
        since = 100;
        repeat (N) begin
            @(posedge ref_clk);
            #1 for (int i = 0; i < 6; i++) begin
                rises[i] += int'(clks[i] & !prev[i]);
                highs[i] += int'(clks[i]);
            end
            since = (lineFrameEdge && !pe) ? 0 : since + 1;
            pe = lineFrameEdge;
            // Once locked, a tick wraps three to five cycles after each frame marker.
            if (m == TRK && clks[0] && !prev[0] && since < 20) begin
                chk("tick after frame", since >= 3 && since <= 5, 1'b1);
            end
            prev = clks;
        end
        for (int i = 0; i < 6; i++) begin
            chk("clock edges", near(rises[i], int'(hz[i] * N / RF), 3), 1'b1);
            if (m != TRK && i > 1) chk("high time", near(highs[i], hi[i] * N / 1000, N / 50), 1'b1);
        end
        $display("clock test done mode %0d select %0d", m, sel);
    endtask : clocks
    task automatic lvl(input logic [1:0] m, input logic lp, input logic lv, input logic own, input logic exp);
        @(posedge ref_clk);
        lineMode <= m;
        analogLoopClosed <= lp;
        lineLevelAbove <= lv;
        ownLoopLevel <= own;
        repeat (8) @(posedge ref_clk);
        #1 chk("signalPresent", signalPresent, exp);
    endtask : lvl
    task automatic xfer(input logic isWr, input int d);
        logic e;
        logic s;
        logic w;
        int   dev;
        e = isWr ? q.size() == 3 : q.size() == 0;
        s = e;
        w = 1'b0;
        seed = lfsr(lfsr(seed));
        repeat (d + 1) @(posedge ref_clk);
        lineWordValid <= isWr;
        portWordReq <= !isWr;
        lineWord <= {seed, seed[1:0]};
        if (isWr && !e) q.push_back({seed, seed[1:0]});
        // Wander is the change in write-to-read age against the age seen at the first read.
        if (!isWr && !e) begin
            dev = centre < 0 ? 0 : (cyc - lastWr > centre ? cyc - lastWr - centre : centre - cyc + lastWr);
            if (centre < 0 || dev > 2000) centre = cyc - lastWr;
            s = dev > 2000;
            w = slipWarnSelect && dev > 1000;
        end
        @(posedge ref_clk);
        lineWordValid <= 1'b0;
        portWordReq <= 1'b0;
        if (isWr) lastWr = cyc;
        #1 chk("slipDetected", slipDetected, s);
        if (!s) chk("slipWarning", slipWarning, w);
        if (!isWr) chk("portWordValid", portWordValid, !e);
        if (!isWr && !e) chk("portWord", portWord, q.pop_front());
        chk("storeFill", storeFill, q.size());
    endtask : xfer
    task automatic summarize();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize
    initial begin
        reset_dut(12);
        clocks(TRM, 1'b0);
        clocks(TRM, 1'b1);
        clocks(TRK, 1'b0);
        lvl(TRM, 1'b1, 1'b1, 1'b0, 1'b1);
        lvl(line_clock_pkg::MODE_NETWORK_TERM, 1'b1, 1'b1, 1'b0, 1'b0);
        lvl(line_clock_pkg::MODE_LINE_TERM, 1'b1, 1'b0, 1'b1, 1'b1);
        lvl(TRK, 1'b1, 1'b1, 1'b0, 1'b1);
        $display("level test done");
        reset_dut(3);
        repeat (4) xfer(1'b1, 0);
        repeat (4) xfer(1'b0, 0);
        $display("store test done");
        reset_dut(3);
        xfer(1'b1, 0);
        xfer(1'b0, 10);
        xfer(1'b1, 0);
        xfer(1'b0, 1500);
        @(posedge ref_clk);
        slipWarnSelect <= 1'b1;
        xfer(1'b1, 0);
        xfer(1'b0, 1500);
        xfer(1'b1, 0);
        xfer(1'b0, 2600);
        $display("slip test done");
        summarize();
    end
endmodule : tb_top
bind line_clock_recovery_elastic_buffer clock_port_monitor mon_u (
    .ref_clk(ref_clk), .rst(rst), .lineMode(lineMode), .slipWarnSelect(slipWarnSelect),
    .lineWordValid(lineWordValid), .portWordReq(portWordReq), .portWordValid(portWordValid),
    .storeFill(storeFill), .portDataClock(portDataClock), .frameSyncClock(frameSyncClock),
    .slipWarning(slipWarning), .slipDetected(slipDetected));
